// file: rtl/aacr_pkg.sv
// shared constants and types for the auxiliary converter control block
package aacr_pkg;
    localparam logic [3:0] MAIN_CTRL = 4'h4;
    localparam logic [3:0] MAIN_CH1A = 4'h5;
    localparam logic [3:0] MAIN_CH1B = 4'h6;
    localparam logic [3:0] MAIN_CH2 = 4'h7;
    localparam logic [3:0] MAIN_CH3 = 4'h8;
    localparam logic [3:0] MAIN_CH4 = 4'h9;
    localparam logic [2:0] SUB_DELAY = 3'h0;
    localparam logic [2:0] SUB_FLAGS = 3'h1;
    localparam logic [2:0] SUB_AUX_OFF = 3'h4;
    localparam logic [2:0] SUB_I_OFF = 3'h5;
    localparam logic [2:0] SUB_Q_OFF = 3'h6;
    localparam logic [2:0] SUB_TRIG = 3'h7;
    localparam int SUB_W = 3;
    localparam int FLAG_1A = 0;
    localparam int FLAG_1B = 1;
    localparam int FLAG_CH2 = 2;
    localparam int FLAG_CH3 = 3;
    localparam int FLAG_CH4 = 4;
    localparam int FLAG_AUX_OFF = 5;
    localparam int FLAG_I_OFF = 6;
    localparam int FLAG_Q_OFF = 7;
    localparam int FLAG_W = 8;
    localparam int TRIG_AUX = 0;
    localparam int TRIG_I = 1;
    localparam int TRIG_Q = 2;
    localparam int DELAY_W = 7;
    localparam int OFF_W = 9;
    localparam int RES_W = 12;
    localparam int DELAY_UNIT_CLK = 48;
    localparam logic [DELAY_W-1:0] DELAY_RST = 7'h00;
    localparam logic [OFF_W-1:0] OFF_RST = 9'h000;
    localparam logic [RES_W-1:0] RES_RST = 12'h000;
    localparam int CLK_MHZ = 200;
    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int CAL_US = 100;
    localparam int CAL_CYC = CAL_US * CLK_MHZ;
    typedef enum logic [2:0] {SEL_CH1, SEL_CH2, SEL_CH3, SEL_CH4,
        SEL_AUX_OFF, SEL_I_OFF, SEL_Q_OFF} aacr_sel_e;
    typedef enum logic [2:0] {ST_IDLE, ST_SETTLE, ST_CONV, ST_CAL} aacr_state_e;
endpackage

// file: rtl/aacr_sub_if.sv
// raw sample and offset in, compensated sample out
interface aacr_sub_if #(parameter int RAW_W = 12, parameter int OFF_W = 9);
    logic [RAW_W-1:0] raw;
    logic [OFF_W-1:0] off;
    logic [RAW_W-1:0] res;
    modport src (output raw, output off, input res);
    modport sub (input raw, input off, output res);
endinterface

// file: rtl/aacr_off_sub.sv
// signed offset subtraction with saturation
module aacr_off_sub #(
    parameter int RAW_W = 12,
    parameter int OFF_W = 9
) (
    aacr_sub_if.sub s
);
    logic signed [RAW_W:0] diff;
    // one guard bit is enough: a 9-bit offset cannot move a 12-bit value further
    assign diff = $signed({s.raw[RAW_W-1], s.raw})
        - $signed({{(RAW_W+1-OFF_W){s.off[OFF_W-1]}}, s.off});
    always_comb
    begin
        if (diff[RAW_W] != diff[RAW_W-1])
            s.res = {diff[RAW_W], {(RAW_W-1){~diff[RAW_W]}}};
        else
            s.res = diff[RAW_W-1:0];
    end
endmodule

// file: rtl/aacr_tick_div.sv
// restartable divider giving a one-cycle tick every DIV clocks
module aacr_tick_div #(
    parameter int DIV = 48
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_restart,
    output logic o_tick
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    logic [CW-1:0] cnt_ff;

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            cnt_ff <= '0;
        else if (i_restart || cnt_ff == LAST)
            cnt_ff <= '0;
        else
            cnt_ff <= cnt_ff + 1'b1;
    end
    assign o_tick = !i_restart && cnt_ff == LAST;
endmodule

// file: rtl/aacr_top.sv
// auxiliary converter control, flags, offsets and result registers
// Behaviour
// [R1] 7-bit delay in 48-clock units from burst rise to in-burst channel 1 conversion
// [R2] settling time is added after the programmed delay before converting
// [R3] a channel's flag is set while its conversion is pending
// [R4] flag word at subaddress 1: 1A,1B,ch2..4, aux/I/Q offset at bits 0..7
// [R5] flag word is read only; writes leave the flags alone
// [R6] three signed 9-bit offsets: auxiliary, I receive, Q receive
// [R7] offsets are subtracted from every receive sample and converter result
// [R8] offsets are readable and writable and reset to zero
// [R9] the block can measure the offsets itself
// [R10] trigger write starts offset measurement for Q bit2, I bit1, aux bit0
// [R11] offset measurements are converter runs done one at a time
// [R12] each offset measurement lasts about 100 microseconds
// [R13] trigger word is write only
// [R14] main address 4 subaddresses: 0 delay,1 flags,4/5/6 offsets,7 trigger
// [R15] 12-bit results at main addresses 5..9: 1A, 1B, ch2, ch3, ch4
// [R16] in-burst channel 1 result stored only while the burst is on
// [R17] out-of-burst channel 1 result stored only while the burst is off
// [R18] subaddress is right aligned in the low subaddress bits
// [R19] a flag clears once its result or offset has been updated
module aacr_top #(
    parameter int CAL_CYC = aacr_pkg::CAL_CYC,
    parameter int SETTLE_CYC = aacr_pkg::SETTLE_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_burst_on,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [3:0] i_reg_addr,
    input wire logic [3:0] i_reg_sub,
    input wire logic [11:0] i_reg_wdata,
    output logic [11:0] o_reg_rdata_ff,
    output logic o_reg_rvalid_ff,
    input wire logic [3:0] i_meas_req,
    output logic o_conv_start_ff,
    output logic [2:0] o_conv_sel_ff,
    input wire logic i_conv_done,
    input wire logic [11:0] i_conv_data,
    input wire logic i_bb_valid,
    input wire logic [11:0] i_bb_i,
    input wire logic [11:0] i_bb_q,
    output logic o_bb_valid_ff,
    output logic [11:0] o_bb_i_ff,
    output logic [11:0] o_bb_q_ff
);
    localparam int RW = aacr_pkg::RES_W;
    localparam int OW = aacr_pkg::OFF_W;
    localparam int CNT_W = $clog2(CAL_CYC + SETTLE_CYC + 1);
    localparam int SETTLE_D = SETTLE_CYC;
    localparam int DLY_UNIT = aacr_pkg::DELAY_UNIT_CLK;

    logic burst_s1_ff, burst_s2_ff, burst_d_ff, burst_rise;
    logic [aacr_pkg::DELAY_W-1:0] delay_ff, dly_cnt_ff;
    logic dly_run_ff, ready1a_ff, is_1a_ff, tick, seen_ff;
    logic [OW-1:0] aux_off_ff, i_off_ff, q_off_ff; // R6
    logic [aacr_pkg::FLAG_W-1:0] flags_ff, flag_set, flag_clr;
    logic [RW-1:0] res1a_ff, res1b_ff, res2_ff, res3_ff, res4_ff, raw_ff;
    logic [CNT_W-1:0] cnt_ff;
    aacr_pkg::aacr_state_e state_ff;
    aacr_pkg::aacr_sel_e sel_ff;
    logic [aacr_pkg::SUB_W-1:0] sub;
    logic ctrl_wr, conv_fin, cal_fin;
    logic [OW-1:0] cal_val;

    aacr_sub_if #(.RAW_W(RW), .OFF_W(OW)) aux_if ();
    aacr_sub_if #(.RAW_W(RW), .OFF_W(OW)) i_if ();
    aacr_sub_if #(.RAW_W(RW), .OFF_W(OW)) q_if ();
    aacr_off_sub #(.RAW_W(RW), .OFF_W(OW)) u_aux_sub (.s(aux_if.sub));
    aacr_off_sub #(.RAW_W(RW), .OFF_W(OW)) u_i_sub (.s(i_if.sub));
    aacr_off_sub #(.RAW_W(RW), .OFF_W(OW)) u_q_sub (.s(q_if.sub));
    assign aux_if.raw = i_conv_data;
    assign aux_if.off = aux_off_ff; // R7
    assign i_if.raw = i_bb_i;
    assign i_if.off = i_off_ff; // R7
    assign q_if.raw = i_bb_q;
    assign q_if.off = q_off_ff; // R7

    aacr_tick_div #(.DIV(DLY_UNIT)) u_div (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_restart(burst_rise),
        .o_tick(tick)
    );

    assign sub = i_reg_sub[aacr_pkg::SUB_W-1:0]; // R18
    assign ctrl_wr = i_reg_wr && i_reg_addr == aacr_pkg::MAIN_CTRL; // R14
    assign burst_rise = burst_s2_ff && !burst_d_ff;
    assign conv_fin = state_ff == aacr_pkg::ST_CONV && i_conv_done;
    assign cal_fin = state_ff == aacr_pkg::ST_CAL && cnt_ff == '0 && (seen_ff || i_conv_done);
    // offset is the raw zero-input reading, clipped to the 9-bit range
    always_comb
    begin
        logic [RW-1:0] r;
        r = seen_ff ? raw_ff : i_conv_data;
        if (r[RW-1] && r[RW-2:OW-1] != {(RW-OW){1'b1}})
            cal_val = {1'b1, {(OW-1){1'b0}}};
        else if (!r[RW-1] && r[RW-2:OW-1] != '0)
            cal_val = {1'b0, {(OW-1){1'b1}}};
        else
            cal_val = r[OW-1:0];
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            burst_s1_ff <= 1'b0;
            burst_s2_ff <= 1'b0;
            burst_d_ff <= 1'b0;
        end
        else
        begin
            burst_s1_ff <= i_burst_on;
            burst_s2_ff <= burst_s1_ff;
            burst_d_ff <= burst_s2_ff;
        end
    end

    // delay runs on its own so a busy converter cannot stretch it
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            dly_run_ff <= 1'b0;
            dly_cnt_ff <= '0;
            ready1a_ff <= 1'b0;
        end
        else if (burst_rise)
        begin
            dly_run_ff <= 1'b1; // R1
            dly_cnt_ff <= '0;
        end
        else
        begin
            // clear first so a delay ending while the sequencer takes the old one is kept
            if (state_ff == aacr_pkg::ST_IDLE && ready1a_ff)
                ready1a_ff <= 1'b0;
            if (dly_run_ff && dly_cnt_ff == delay_ff)
            begin
                dly_run_ff <= 1'b0;
                ready1a_ff <= 1'b1; // R1
            end
            else if (dly_run_ff && tick)
                dly_cnt_ff <= dly_cnt_ff + 1'b1;
        end
    end

    always_comb
    begin
        flag_set = '0;
        flag_clr = '0;
        flag_set[aacr_pkg::FLAG_1A] = burst_rise; // R3
        flag_set[aacr_pkg::FLAG_1B] = i_meas_req[0] && !burst_s2_ff; // R3
        flag_set[aacr_pkg::FLAG_CH2] = i_meas_req[1];
        flag_set[aacr_pkg::FLAG_CH3] = i_meas_req[2];
        flag_set[aacr_pkg::FLAG_CH4] = i_meas_req[3];
        if (ctrl_wr && sub == aacr_pkg::SUB_TRIG)
        begin
            flag_set[aacr_pkg::FLAG_AUX_OFF] = i_reg_wdata[aacr_pkg::TRIG_AUX]; // R10
            flag_set[aacr_pkg::FLAG_I_OFF] = i_reg_wdata[aacr_pkg::TRIG_I]; // R10
            flag_set[aacr_pkg::FLAG_Q_OFF] = i_reg_wdata[aacr_pkg::TRIG_Q]; // R10
        end
        if (conv_fin)
        begin
            if (sel_ff == aacr_pkg::SEL_CH1)
                flag_clr[is_1a_ff ? aacr_pkg::FLAG_1A : aacr_pkg::FLAG_1B] = 1'b1; // R19
            else
                flag_clr[aacr_pkg::FLAG_CH2 + int'(sel_ff) - 1] = 1'b1; // R19
        end
        if (cal_fin)
            flag_clr[aacr_pkg::FLAG_AUX_OFF + int'(sel_ff) - 4] = 1'b1; // R19
    end

    // set wins over clear; host writes reach this register only as trigger bits through flag_set
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            flags_ff <= '0;
        else
            flags_ff <= (flags_ff & ~flag_clr) | flag_set; // R5
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            delay_ff <= aacr_pkg::DELAY_RST;
            aux_off_ff <= aacr_pkg::OFF_RST;
            i_off_ff <= aacr_pkg::OFF_RST; // R8
            q_off_ff <= aacr_pkg::OFF_RST;
        end
        else
        begin
            if (ctrl_wr && sub == aacr_pkg::SUB_DELAY)
                delay_ff <= i_reg_wdata[aacr_pkg::DELAY_W-1:0];
            // a finishing self-measurement outranks a host write in the same cycle
            if (cal_fin && sel_ff == aacr_pkg::SEL_AUX_OFF)
                aux_off_ff <= cal_val; // R9
            else if (ctrl_wr && sub == aacr_pkg::SUB_AUX_OFF)
                aux_off_ff <= i_reg_wdata[OW-1:0]; // R8
            if (cal_fin && sel_ff == aacr_pkg::SEL_I_OFF)
                i_off_ff <= cal_val; // R9
            else if (ctrl_wr && sub == aacr_pkg::SUB_I_OFF)
                i_off_ff <= i_reg_wdata[OW-1:0]; // R8
            if (cal_fin && sel_ff == aacr_pkg::SEL_Q_OFF)
                q_off_ff <= cal_val; // R9
            else if (ctrl_wr && sub == aacr_pkg::SUB_Q_OFF)
                q_off_ff <= i_reg_wdata[OW-1:0]; // R8
        end
    end

    // single sequencer: only one conversion or measurement at a time
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state_ff <= aacr_pkg::ST_IDLE;
            sel_ff <= aacr_pkg::SEL_CH1;
            is_1a_ff <= 1'b0;
            cnt_ff <= '0;
            seen_ff <= 1'b0;
            raw_ff <= aacr_pkg::RES_RST;
            o_conv_start_ff <= 1'b0;
            o_conv_sel_ff <= '0;
        end
        else
        begin
            o_conv_start_ff <= 1'b0;
            case (state_ff)
                aacr_pkg::ST_IDLE:
                begin
                    cnt_ff <= CNT_W'(SETTLE_CYC - 1); // R2
                    seen_ff <= 1'b0;
                    state_ff <= aacr_pkg::ST_SETTLE;
                    is_1a_ff <= 1'b0;
                    if (ready1a_ff)
                    begin
                        sel_ff <= aacr_pkg::SEL_CH1;
                        is_1a_ff <= 1'b1;
                    end
                    else if (|flags_ff[aacr_pkg::FLAG_Q_OFF:aacr_pkg::FLAG_AUX_OFF])
                    begin
                        state_ff <= aacr_pkg::ST_CAL; // R11
                        cnt_ff <= CNT_W'(CAL_CYC - 1); // R12
                        o_conv_start_ff <= 1'b1;
                        if (flags_ff[aacr_pkg::FLAG_AUX_OFF])
                            sel_ff <= aacr_pkg::SEL_AUX_OFF;
                        else if (flags_ff[aacr_pkg::FLAG_I_OFF])
                            sel_ff <= aacr_pkg::SEL_I_OFF;
                        else
                            sel_ff <= aacr_pkg::SEL_Q_OFF;
                        o_conv_sel_ff <= flags_ff[aacr_pkg::FLAG_AUX_OFF] ? 3'h4 :
                            (flags_ff[aacr_pkg::FLAG_I_OFF] ? 3'h5 : 3'h6);
                    end
                    else if (flags_ff[aacr_pkg::FLAG_1B])
                        sel_ff <= aacr_pkg::SEL_CH1;
                    else if (flags_ff[aacr_pkg::FLAG_CH2])
                        sel_ff <= aacr_pkg::SEL_CH2;
                    else if (flags_ff[aacr_pkg::FLAG_CH3])
                        sel_ff <= aacr_pkg::SEL_CH3;
                    else if (flags_ff[aacr_pkg::FLAG_CH4])
                        sel_ff <= aacr_pkg::SEL_CH4;
                    else
                        state_ff <= aacr_pkg::ST_IDLE;
                end
                aacr_pkg::ST_SETTLE:
                begin
                    cnt_ff <= cnt_ff - 1'b1;
                    if (cnt_ff == '0)
                    begin
                        o_conv_start_ff <= 1'b1; // R2
                        o_conv_sel_ff <= sel_ff;
                        state_ff <= aacr_pkg::ST_CONV;
                    end
                end
                aacr_pkg::ST_CONV:
                    if (i_conv_done)
                        state_ff <= aacr_pkg::ST_IDLE;
                aacr_pkg::ST_CAL:
                begin
                    if (cnt_ff != '0)
                        cnt_ff <= cnt_ff - 1'b1;
                    if (i_conv_done && !seen_ff)
                    begin
                        seen_ff <= 1'b1;
                        raw_ff <= i_conv_data;
                    end
                    if (cal_fin)
                        state_ff <= aacr_pkg::ST_IDLE; // R11
                end
                default:
                    state_ff <= aacr_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            res1a_ff <= aacr_pkg::RES_RST;
            res1b_ff <= aacr_pkg::RES_RST;
            res2_ff <= aacr_pkg::RES_RST;
            res3_ff <= aacr_pkg::RES_RST;
            res4_ff <= aacr_pkg::RES_RST;
        end
        else if (conv_fin)
        begin
            case (sel_ff)
                aacr_pkg::SEL_CH1:
                    if (is_1a_ff && burst_s2_ff)
                        res1a_ff <= aux_if.res; // R16
                    else if (!is_1a_ff && !burst_s2_ff)
                        res1b_ff <= aux_if.res; // R17
                aacr_pkg::SEL_CH2:
                    res2_ff <= aux_if.res; // R7
                aacr_pkg::SEL_CH3:
                    res3_ff <= aux_if.res;
                aacr_pkg::SEL_CH4:
                    res4_ff <= aux_if.res;
                default:
                    res4_ff <= res4_ff;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_bb_valid_ff <= 1'b0;
            o_bb_i_ff <= aacr_pkg::RES_RST;
            o_bb_q_ff <= aacr_pkg::RES_RST;
        end
        else
        begin
            o_bb_valid_ff <= i_bb_valid;
            if (i_bb_valid)
            begin
                o_bb_i_ff <= i_if.res; // R7
                o_bb_q_ff <= q_if.res; // R7
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_reg_rvalid_ff <= 1'b0;
            o_reg_rdata_ff <= '0;
        end
        else
        begin
            o_reg_rvalid_ff <= i_reg_rd;
            o_reg_rdata_ff <= '0; // trigger and unmapped addresses read zero
            if (i_reg_rd)
            begin
                case (i_reg_addr)
                    aacr_pkg::MAIN_CTRL:
                        case (sub) // R14
                            aacr_pkg::SUB_DELAY: o_reg_rdata_ff <= 12'(delay_ff);
                            aacr_pkg::SUB_FLAGS: o_reg_rdata_ff <= 12'(flags_ff); // R4
                            aacr_pkg::SUB_AUX_OFF: o_reg_rdata_ff <= 12'(aux_off_ff);
                            aacr_pkg::SUB_I_OFF: o_reg_rdata_ff <= 12'(i_off_ff);
                            aacr_pkg::SUB_Q_OFF: o_reg_rdata_ff <= 12'(q_off_ff);
                            default: o_reg_rdata_ff <= '0; // R13
                        endcase
                    aacr_pkg::MAIN_CH1A: o_reg_rdata_ff <= res1a_ff; // R15
                    aacr_pkg::MAIN_CH1B: o_reg_rdata_ff <= res1b_ff;
                    aacr_pkg::MAIN_CH2: o_reg_rdata_ff <= res2_ff;
                    aacr_pkg::MAIN_CH3: o_reg_rdata_ff <= res3_ff;
                    aacr_pkg::MAIN_CH4: o_reg_rdata_ff <= res4_ff;
                    default: o_reg_rdata_ff <= '0;
                endcase
            end
        end
    end

    // checking helpers
    logic [15:0] age_ff;
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            age_ff <= '0;
        else if (burst_rise)
            age_ff <= '0;
        else if (age_ff != 16'hFFFF)
            age_ff <= age_ff + 1'b1;
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    delay_time_a: assert property ($rose(ready1a_ff) && dly_run_ff == 1'b0 |-> // R1
        age_ff == 16'(int'(delay_ff) * DLY_UNIT + 1))
        else $error("in-burst delay length wrong");
    settle_time_a: assert property (state_ff != aacr_pkg::ST_SETTLE ##1 // R2
        state_ff == aacr_pkg::ST_SETTLE |-> ##SETTLE_D o_conv_start_ff)
        else $error("settling time not honoured");
    flags_ro_a: assert property (ctrl_wr && sub == aacr_pkg::SUB_FLAGS && flag_set == '0 // R5
        && flag_clr == '0 |=> $stable(flags_ff))
        else $error("flag word changed by a write");
    trig_set_a: assert property (ctrl_wr && sub == aacr_pkg::SUB_TRIG // R10
        && i_reg_wdata[aacr_pkg::TRIG_Q] |=> flags_ff[aacr_pkg::FLAG_Q_OFF])
        else $error("trigger did not request measurement");
    one_at_time_a: assert property ((state_ff == aacr_pkg::ST_CONV // R11
        || state_ff == aacr_pkg::ST_CAL) && !conv_fin |=> !o_conv_start_ff)
        else $error("second conversion started while busy");
    cal_time_a: assert property (cal_fin |-> $past(state_ff, 8) == aacr_pkg::ST_CAL // R12
        && cnt_ff == '0) else $error("offset measurement ended early");
    in_burst_a: assert property (res1a_ff != $past(res1a_ff) |-> $past(burst_s2_ff)) // R16
        else $error("in-burst result stored outside burst");
    out_burst_a: assert property (res1b_ff != $past(res1b_ff) |-> !$past(burst_s2_ff)) // R17
        else $error("out-of-burst result stored during burst");
    bb_pass_a: assert property (i_bb_valid && i_off_ff == '0 |=> o_bb_i_ff == $past(i_bb_i)) // R7
        else $error("receive sample altered with zero offset");
    flag_clear_a: assert property (conv_fin && sel_ff == aacr_pkg::SEL_CH2 // R19
        && !i_meas_req[1] |=> !flags_ff[aacr_pkg::FLAG_CH2])
        else $error("channel 2 flag not cleared");
    cover_1a: cover property (conv_fin && is_1a_ff && burst_s2_ff);
    cover_1b: cover property (conv_fin && !is_1a_ff && sel_ff == aacr_pkg::SEL_CH1);
    cover_cal: cover property (cal_fin && sel_ff == aacr_pkg::SEL_Q_OFF);
endmodule

// file: tb/aacr_conv_model.sv
// converter stand-in: answers every start pulse after a fixed latency
module aacr_conv_model #(parameter int LAT = 3) (
    input wire logic i_core_clk,
    input wire logic i_start,
    input wire logic [11:0] i_val,
    output logic o_done,
    output logic [11:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    logic [11:0] hold = 12'h000;
    initial o_done = 1'b0;
    initial o_data = 12'h000;
    always @(posedge i_core_clk)
    begin
        o_done <= (cnt == 1);
        // data only valid with done, otherwise it toggles
        o_data <= (cnt == 1) ? hold : ~o_data;
        if (i_start)
        begin
            cnt <= LAT;
            hold <= i_val;
        end
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
endmodule

// file: tb/aacr_top_tb.sv
// self-checking bench for the converter control block
module aacr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, burst = 0, wr = 0, rd = 0, bbv = 0, done, rv, st, obv;
    logic [3:0] adr = 0, sub = 0, req = 0;
    logic [11:0] wd = 0, rdat, cval = 0, cdat, bi = 0, bq = 0, oi, oq, q;
    logic [2:0] sel;
    int mismatches = 0, checked = 0, seed = 42, cyc = 0, t0;
    int off[3];
    int tq[$], sq[$];
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) cyc++;
    always @(negedge clk) if (st === 1'b1) begin tq.push_back(cyc); sq.push_back(sel); end
    aacr_top #(.CAL_CYC(40), .SETTLE_CYC(4)) i_aacr_top (.i_core_clk(clk), .i_sys_rst(rst),
        .i_burst_on(burst), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(adr), .i_reg_sub(sub),
        .i_reg_wdata(wd), .o_reg_rdata_ff(rdat), .o_reg_rvalid_ff(rv), .i_meas_req(req),
        .o_conv_start_ff(st), .o_conv_sel_ff(sel), .i_conv_done(done), .i_conv_data(cdat),
        .i_bb_valid(bbv), .i_bb_i(bi), .i_bb_q(bq), .o_bb_valid_ff(obv), .o_bb_i_ff(oi),
        .o_bb_q_ff(oq));
    aacr_conv_model i_aacr_conv_model (.i_core_clk(clk), .i_start(st), .i_val(cval),
        .o_done(done), .o_data(cdat));
    function automatic logic [11:0] sat(int v, int lim);
        return 12'(v > lim - 1 ? lim - 1 : (v < -lim ? -lim : v));
    endfunction
    task automatic cmp(string what, logic [11:0] exp, logic [11:0] got);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // subaddress sits right aligned, top subaddress bit unused
    task automatic acc(logic w, logic [3:0] a, logic [2:0] s, logic [11:0] d);
        @(negedge clk);
        wr = w;
        rd = !w;
        adr = a;
        sub = {1'b0, s};
        wd = d;
        @(negedge clk);
        wr = 0;
        rd = 0;
        q = rv ? rdat : 12'hFFF;
    endtask
    task automatic idle;
        repeat (300)
        begin
            acc(0, 4, 1, 0);
            if (q === 12'h000)
                break;
        end
        cmp("flags idle", 0, q);
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #60000;
        mismatches++;
        conclude();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst = 0;
        for (int s = 0; s < 8; s++)
        begin
            acc(0, 4, 3'(s), 0);
            cmp("ctrl reset", 0, q);
        end
        for (int k = 0; k < 3; k++)
        begin
            off[k] = $random(seed) % 256;
            acc(1, 4, 3'(4 + k), 12'(off[k]) & 12'h1FF);
            acc(0, 4, 3'(4 + k), 0);
            cmp("offset", 12'(off[k]) & 12'h1FF, q);
        end
        acc(1, 4, 0, 12'hFFF);
        acc(0, 4, 0, 0);
        cmp("delay", 12'h07F, q);
        acc(1, 4, 1, 12'h0FF);
        acc(0, 4, 1, 0);
        cmp("flags ro", 0, q);
        acc(0, 4'hA, 0, 0);
        cmp("unmapped", 0, q);
        for (int k = 0; k < 8; k++)
        begin
            if (k == 6)
            begin
                // last samples with no I offset, so plain pass-through is seen too
                acc(1, 4, 5, 0);
                off[1] = 0;
            end
            @(negedge clk);
            bbv = 1;
            bi = 12'($random(seed));
            bq = 12'($random(seed));
            @(negedge clk);
            bbv = 0;
            cmp("rx valid", 1, {11'h000, obv});
            cmp("rx i", sat(int'($signed(bi)) - off[1], 2048), oi);
            cmp("rx q", sat(int'($signed(bq)) - off[2], 2048), oq);
        end
        for (int c = 0; c < 4; c++)
        begin
            cval = 12'($random(seed));
            @(negedge clk);
            req = 4'h1 << c;
            @(negedge clk);
            req = 0;
            acc(0, 4, 1, 0);
            cmp("flag set", c == 0 ? 12'h002 : 12'h001 << (c + 1), q);
            idle();
            acc(0, 4'(6 + c), 0, 0);
            cmp("result", sat(int'($signed(cval)) - off[0], 2048), q);
        end
        cval = 12'($random(seed));
        acc(1, 4, 7, 12'h007);
        acc(0, 4, 1, 0);
        cmp("cal flags", 12'h0E0, q);
        idle();
        for (int k = 0; k < 3; k++)
        begin
            off[k] = int'($signed(sat(int'($signed(cval)), 256)));
            acc(0, 4, 3'(4 + k), 0);
            cmp("cal offset", 12'(off[k]) & 12'h1FF, q);
            cmp("cal order", 12'(4 + k), 12'(sq[sq.size() - 3 + k]));
        end
        cmp("cal spacing", 1, 12'(tq[$] - tq[tq.size() - 2] >= 40));
        acc(1, 4, 0, 12'h001);
        cval = 12'($random(seed));
        @(negedge clk);
        burst = 1;
        t0 = cyc;
        repeat (4) @(negedge clk);
        acc(0, 4, 1, 0);
        cmp("burst flag", 12'h001, q);
        idle();
        // sync, 48-clock unit, settling and sequencer slack
        cmp("burst delay", 1, 12'(tq[$] - t0 >= 52 && tq[$] - t0 <= 62));
        acc(0, 5, 0, 0);
        cmp("in burst", sat(int'($signed(cval)) - off[0], 2048), q);
        burst = 0;
        conclude();
    end
endmodule
